// ---- hw/sadc_top.sv ----
// Sequencer of the ten-bit successive-approximation converter with its register file
// How it works
// [RULE_01] Start bit in single mode converts channel
// [RULE_02] Completion loads result, flag, interrupt together
// [RULE_03] Start bit clears itself once begun
// [RULE_04] Software waits for completion before restarting
// [RULE_05] Start bit in repeat mode starts repeating
// [RULE_06] Repeat mode restarts after each completion
// [RULE_07] Disable code halts running conversion immediately
// [RULE_08] Aborted conversion leaves result untouched
// [RULE_09] Software programs all fields before starting
// [RULE_10] Completion only after programmed conversion time
// [RULE_11] Reading result clears the completion flag
// [RULE_12] New start clears flag, keeps old result
// [RULE_13] Stop or slow aborts, resets, clears result
// [RULE_14] After standby stay idle until restarted
// [RULE_15] Standby disconnects reference ladder
// [RULE_16] Result is ten-bit unsigned code
// [RULE_17] Time select gives six cycle lengths
// [RULE_18] Busy flag marks a running conversion
// [RULE_19] Standby holds control registers, ignores writes
// [RULE_20] Reserved mode code behaves as disabled
// [RULE_21] Start while busy is ignored
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"
module sadc_top import sadc_pkg::*; #(
   parameter int LEN_W = 11
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic standby_stop_slow,
   input wire logic standby_sleep,
   input wire logic comparator_above,
   output logic [9:0] dac_code,
   output logic [2:0] channel_select,
   output logic channel_enable,
   output logic ladder_connect,
   output logic conv_busy_flag,
   output logic conv_done_irq
);
   sadc_tmr_if #(.LEN_W(LEN_W)) tif ();

   sadc_timer #(.LEN_W(LEN_W)) sadc_timer_inst (
      .clock(clock),
      .rst_n(rst_n),
      .tif(tif.tmr)
   );

   logic conv_start_bit;
   sadc_mode_t op_mode_sel;
   logic analog_input_disable;
   logic [3:0] chan;
   logic [`SADC_C2_HI:0] conv_control_reg2;
   sadc_code_t result;
   logic conv_done_flag;
   sadc_state_e state;
   logic hold;
   logic mode_ok;
   logic start_go;
   logic reload;
   logic abort;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic rd_upper;
   logic set_done;
   sadc_code_t next_dac;
   logic [7:0] next_rdata;

   function automatic logic [LEN_W-1:0] conv_len(input logic [2:0] code);
      logic [LEN_W-1:0] n;
      n = LEN_W'(`SADC_CYC_1248);
      case (code)
         `SADC_ACK_39: n = LEN_W'(`SADC_CYC_39);
         `SADC_ACK_78: n = LEN_W'(`SADC_CYC_78);
         `SADC_ACK_156: n = LEN_W'(`SADC_CYC_156);
         `SADC_ACK_312: n = LEN_W'(`SADC_CYC_312);
         `SADC_ACK_624: n = LEN_W'(`SADC_CYC_624);
         `SADC_ACK_1248: n = LEN_W'(`SADC_CYC_1248);
         default: n = LEN_W'(`SADC_CYC_1248);
      endcase
      return n;
   endfunction

   assign hold = standby_stop_slow || standby_sleep;
   assign wr_ctrl1 = reg_write && (reg_addr == `SADC_OFS_CTRL1);
   assign wr_ctrl2 = reg_write && (reg_addr == `SADC_OFS_CTRL2);
   assign rd_upper = reg_read && (reg_addr == `SADC_OFS_UPPER);

   // [RULE_20] Only single and repeat codes run
   assign mode_ok = (op_mode_sel == `SADC_MODE_SW) || (op_mode_sel == `SADC_MODE_REP);
   // [RULE_21] Start honoured only when idle
   assign start_go = conv_start_bit && (state == sadc_idle) && mode_ok && !hold;
   // [RULE_06] Restart on completion in repeat mode
   assign reload = tif.finish && (op_mode_sel == `SADC_MODE_REP) && !hold;
   // [RULE_07] Disable or standby halts at once
   assign abort = (state == sadc_conv) && (!mode_ok || hold);
   assign set_done = tif.finish;

   assign tif.load = start_go || reload;
   assign tif.abort = abort;
   // [RULE_17] Cycle length from time select
   assign tif.len = conv_len(conv_control_reg2[`SADC_C2_ACK_HI:`SADC_C2_ACK_LO]);

   // Control register 1
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {conv_start_bit, op_mode_sel, analog_input_disable, chan} <= `SADC_CTRL1_RST;
      end else if (hold) begin
         // [RULE_19] Held at initial value
         {conv_start_bit, op_mode_sel, analog_input_disable, chan} <= `SADC_CTRL1_RST;
      end else if (wr_ctrl1) begin
         conv_start_bit <= reg_wdata[`SADC_C1_START];
         op_mode_sel <= reg_wdata[`SADC_C1_MODE_HI:`SADC_C1_MODE_LO];
         analog_input_disable <= reg_wdata[`SADC_C1_AIN_DIS];
         chan <= reg_wdata[`SADC_C1_CHAN_HI:`SADC_C1_CHAN_LO];
      end else if (conv_start_bit) begin
         // [RULE_03] Consumed start bit drops
         conv_start_bit <= 1'b0;
      end
   end

   // Control register 2
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_control_reg2 <= `SADC_CTRL2_RST;
      end else if (hold) begin
         // [RULE_13] Reinitialised in standby
         conv_control_reg2 <= `SADC_CTRL2_RST;
      end else if (wr_ctrl2) begin
         conv_control_reg2 <= reg_wdata[`SADC_C2_HI:0];
      end
   end

   // Sequencer state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= sadc_idle;
      end else begin
         case (state)
            sadc_idle: begin
               // [RULE_01] Software start begins conversion
               // [RULE_05] Same start in repeat mode
               // [RULE_14] Needs a fresh start request
               if (start_go) begin
                  state <= sadc_conv;
               end
            end
            sadc_conv: begin
               if (abort) begin
                  state <= sadc_idle;
               end else if (tif.finish && !reload) begin
                  state <= sadc_idle;
               end
            end
            default: state <= sadc_idle;
         endcase
      end
   end

   // [RULE_16] Successive approximation, MSB first
   always_comb begin
      next_dac = dac_code;
      if (tif.step) begin
         next_dac[tif.bit_idx] = comparator_above;
         if (tif.bit_idx != 4'h0) begin
            next_dac[tif.bit_idx - 4'h1] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dac_code <= `SADC_RESULT_RST;
      end else if (standby_stop_slow) begin
         dac_code <= `SADC_RESULT_RST;
      end else if (tif.load) begin
         dac_code <= `SADC_DAC_FIRST;
      end else begin
         dac_code <= next_dac;
      end
   end

   // Result store
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result <= `SADC_RESULT_RST;
      end else if (standby_stop_slow) begin
         // [RULE_13] Earlier results cleared
         result <= `SADC_RESULT_RST;
      end else if (tif.finish) begin
         // [RULE_08] Abort suppresses finish
         // [RULE_12] Old result kept until completion
         result <= next_dac;
      end
   end

   // Completion flag, set wins over clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_done_flag <= 1'b0;
      end else if (set_done) begin
         // [RULE_02] Flag with result load
         conv_done_flag <= 1'b1;
      end else if (standby_stop_slow) begin
         conv_done_flag <= 1'b0;
      end else if (rd_upper || start_go) begin
         // [RULE_11] Cleared by result read
         // [RULE_12] Cleared by new start
         conv_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_done_irq <= 1'b0;
      end else begin
         // [RULE_02] Interrupt pulse at completion
         conv_done_irq <= set_done;
      end
   end

   // Busy flag follows the next state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_busy_flag <= 1'b0;
      end else begin
         // [RULE_18] Busy through conversion
         conv_busy_flag <= start_go || ((state == sadc_conv) && !abort && !(tif.finish && !reload));
      end
   end

   // Analog side controls
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         channel_select <= 3'h0;
         channel_enable <= 1'b0;
         ladder_connect <= 1'b0;
      end else begin
         channel_select <= chan[2:0];
         channel_enable <= !analog_input_disable && !chan[3] && !hold;
         // [RULE_15] Reference cut in standby
         ladder_connect <= !hold && (conv_control_reg2[`SADC_C2_LADDER] || conv_busy_flag);
      end
   end

   // Read data one cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         `SADC_OFS_CTRL1: next_rdata = {conv_start_bit, op_mode_sel, analog_input_disable, chan};
         `SADC_OFS_CTRL2: next_rdata = {2'h0, conv_control_reg2};
         `SADC_OFS_UPPER: next_rdata = result[9:2];
         `SADC_OFS_LOWER: next_rdata = {result[1:0], conv_done_flag, conv_busy_flag, 4'h0};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Checking helpers
   logic [LEN_W-1:0] run_cyc;
   logic [LEN_W-1:0] len_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_cyc <= '0;
         len_q <= '0;
      end else if (tif.load) begin
         run_cyc <= '0;
         len_q <= tif.len;
      end else if (tif.running) begin
         run_cyc <= run_cyc + 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Sequencer checks
   a_start_begins: assert property (start_go && op_mode_sel == `SADC_MODE_SW |=> conv_busy_flag ##0 tif.running) // [RULE_01]
      else $error("single start did not begin conversion");
   a_done_with_irq: assert property (conv_done_irq |-> conv_done_flag && result == $past(next_dac)) // [RULE_02]
      else $error("interrupt without completion flag");
   a_flag_with_finish: assert property (tif.finish |=> conv_done_flag && conv_done_irq) // [RULE_02]
      else $error("completion did not raise flag and interrupt");
   a_irq_single: assert property (conv_done_irq |=> !conv_done_irq) // [RULE_02]
      else $error("interrupt longer than one cycle");
   a_busy_state: assert property (conv_busy_flag == tif.running) // [RULE_18]
      else $error("busy flag differs from running timer");
   a_ref_standby: assert property (hold |=> !ladder_connect && !channel_enable) // [RULE_15]
      else $error("reference left connected in standby");
   a_reserved_idle: assert property (conv_start_bit && !mode_ok |=> !conv_busy_flag) // [RULE_20]
      else $error("start accepted in disabled mode");
   a_stop_regs: assert property (standby_stop_slow |=> conv_control_reg2 == '0 && !conv_start_bit) // [RULE_13]
      else $error("standby left control registers set");
   a_sleep_keeps: assert property (standby_sleep && !standby_stop_slow |=> $stable(result)) // [RULE_08]
      else $error("sleep disturbed the result");
   a_dac_first: assert property (tif.load |=> dac_code == `SADC_DAC_FIRST) // [RULE_16]
      else $error("first trial code wrong");
   a_start_selfclear: assert property (conv_start_bit && !wr_ctrl1 |=> !conv_start_bit) // [RULE_03]
      else $error("start bit did not clear");
   a_repeat_restart: assert property (reload |=> conv_busy_flag && run_cyc == '0 ##1 tif.running) // [RULE_06]
      else $error("repeat mode did not restart");
   a_disable_halt: assert property (state == sadc_conv && op_mode_sel == `SADC_MODE_DIS |=> !conv_busy_flag && !tif.running) // [RULE_07]
      else $error("disable did not halt conversion");
   a_abort_keeps: assert property (abort && !standby_stop_slow |=> $stable(result) && !conv_done_irq) // [RULE_08]
      else $error("aborted conversion changed result");
   a_conv_length: assert property (tif.finish |-> run_cyc == len_q - 1'b1) // [RULE_10]
      else $error("conversion length wrong");
   a_read_clears: assert property (rd_upper && !set_done && !standby_stop_slow |=> !conv_done_flag) // [RULE_11]
      else $error("result read did not clear flag");
   a_restart_keeps: assert property (start_go |=> !conv_done_flag && $stable(result)) // [RULE_12]
      else $error("restart disturbed old result");
   a_stop_clears: assert property (standby_stop_slow |=> result == '0 && !conv_busy_flag && !ladder_connect) // [RULE_13]
      else $error("standby did not reinitialise");
   a_sleep_ignores: assert property (hold && reg_write |=> op_mode_sel == `SADC_MODE_DIS && conv_control_reg2 == '0) // [RULE_19]
      else $error("control write accepted in standby");
   a_busy_ignore: assert property (conv_start_bit && state == sadc_conv && !tif.finish && !abort // [RULE_21]
      |-> !start_go ##1 (tif.running && run_cyc == $past(run_cyc) + 1'b1))
      else $error("start accepted while busy");

   // Coverage of the main scenarios
   c_single_done: cover property (tif.finish && len_q == LEN_W'(`SADC_CYC_1248));
   c_repeat_twice: cover property (reload ##[1:1000] reload);
   c_abort_run: cover property (state == sadc_conv ##1 abort);
   c_stop_abort: cover property (abort && standby_stop_slow);
   c_busy_start: cover property (conv_start_bit && state == sadc_conv);
endmodule
`default_nettype wire

// ---- include/sadc_map.svh ----
// Register offsets, field positions, reset values and cycle counts of the converter sequencer
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

`define SADC_OFS_CTRL1 2'h0
`define SADC_OFS_CTRL2 2'h1
`define SADC_OFS_UPPER 2'h2
`define SADC_OFS_LOWER 2'h3

`define SADC_C1_START 7
`define SADC_C1_MODE_HI 6
`define SADC_C1_MODE_LO 5
`define SADC_C1_AIN_DIS 4
`define SADC_C1_CHAN_HI 3
`define SADC_C1_CHAN_LO 0

`define SADC_C2_LADDER 5
`define SADC_C2_ACK_HI 3
`define SADC_C2_ACK_LO 1
`define SADC_C2_HI 5

`define SADC_ST_DONE 5
`define SADC_ST_BUSY 4

`define SADC_CTRL1_RST 8'h00
`define SADC_CTRL2_RST 6'h00
`define SADC_RESULT_RST 10'h000
`define SADC_DAC_FIRST 10'h200

`define SADC_MODE_DIS 2'h0
`define SADC_MODE_SW 2'h1
`define SADC_MODE_RSV 2'h2
`define SADC_MODE_REP 2'h3

`define SADC_ACK_39 3'h0
`define SADC_ACK_78 3'h2
`define SADC_ACK_156 3'h3
`define SADC_ACK_312 3'h4
`define SADC_ACK_624 3'h5
`define SADC_ACK_1248 3'h6

`define SADC_CYC_39 11'h027
`define SADC_CYC_78 11'h04e
`define SADC_CYC_156 11'h09c
`define SADC_CYC_312 11'h138
`define SADC_CYC_624 11'h270
`define SADC_CYC_1248 11'h4e0

`define SADC_TRIALS 4'ha

`endif

// ---- include/sadc_pkg.sv ----
// Types shared by the converter sequencer modules
package sadc_pkg;
   typedef enum logic {sadc_idle, sadc_conv} sadc_state_e;
   typedef logic [9:0] sadc_code_t;
   typedef logic [1:0] sadc_mode_t;
endpackage

// ---- include/sadc_tmr_if.sv ----
// Link between the sequencer and its conversion timer
`timescale 1ns/1ps
`default_nettype none
interface sadc_tmr_if #(parameter int LEN_W = 11);
   logic load;
   logic abort;
   logic [LEN_W-1:0] len;
   logic running;
   logic step;
   logic [3:0] bit_idx;
   logic finish;
   modport ctl (output load, output abort, output len, input running, input step, input bit_idx, input finish);
   modport tmr (input load, input abort, input len, output running, output step, output bit_idx, output finish);
endinterface
`default_nettype wire

// ---- hw/sadc_timer.sv ----
// Conversion timer: counts the conversion length and paces the bit trials
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"
module sadc_timer import sadc_pkg::*; #(
   parameter int LEN_W = 11
) (
   input wire logic clock,
   input wire logic rst_n,
   sadc_tmr_if.tmr tif
);
   logic [LEN_W-1:0] cnt;
   logic run;

   // Abort wins, then a new load, then counting down
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run <= 1'b0;
         cnt <= '0;
      end else if (tif.abort) begin
         run <= 1'b0;
      end else if (tif.load) begin
         run <= 1'b1;
         cnt <= tif.len - 1'b1;
      end else if (run) begin
         if (cnt == '0) begin
            run <= 1'b0;
         end else begin
            cnt <= cnt - 1'b1;
         end
      end
   end

   assign tif.running = run;
   // [RULE_10] Trials fill the final cycles
   assign tif.step = run && !tif.abort && (cnt < LEN_W'(`SADC_TRIALS));
   assign tif.bit_idx = cnt[3:0];
   assign tif.finish = run && !tif.abort && (cnt == '0);
endmodule
`default_nettype wire

// ---- verif/sadc_analog_src.sv ----
// Analog source model: eight input levels feeding the comparator
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_src import sadc_pkg::*; (
   input wire logic clock,
   input wire sadc_code_t level [8],
   input wire logic [9:0] dac_code,
   input wire logic [2:0] channel_select,
   input wire logic channel_enable,
   output logic comparator_above
);
   logic wander = 1'b0;
   // Floating input when disconnected
   always @(posedge clock) begin
      wander <= ~wander;
   end
   always_comb begin
      if (channel_enable) begin
         comparator_above = (level[channel_select] >= dac_code);
      end else begin
         comparator_above = wander;
      end
   end
endmodule
`default_nettype wire

// ---- verif/sar_adc_sequencer_tb.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"
module sar_adc_sequencer_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic standby_stop_slow = 1'b0;
   logic standby_sleep = 1'b0;
   logic [7:0] reg_rdata;
   logic comparator_above, channel_enable, ladder_connect, conv_busy_flag, conv_done_irq;
   logic [9:0] dac_code;
   logic [2:0] channel_select;
   logic [9:0] level [8] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h0f3, 10'h200, 10'h1ff, 10'h30c};
   logic [7:0] d, st;
   logic [9:0] r;
   int fail_count = 0;
   int samples_checked = 0;
   int n;
   always #5 clock = ~clock;
   sadc_top #(.LEN_W(11)) sadc_top_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .standby_stop_slow(standby_stop_slow), .standby_sleep(standby_sleep),
      .comparator_above(comparator_above), .dac_code(dac_code), .channel_select(channel_select),
      .channel_enable(channel_enable), .ladder_connect(ladder_connect),
      .conv_busy_flag(conv_busy_flag), .conv_done_irq(conv_done_irq));
   sadc_analog_src sadc_analog_src_inst (.clock(clock), .level(level), .dac_code(dac_code),
      .channel_select(channel_select), .channel_enable(channel_enable),
      .comparator_above(comparator_above));
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      v = reg_rdata;
   endtask
   task automatic get_result;
      rd(2'h3, st);
      rd(2'h2, d);
      r = {d, st[7:6]};
   endtask
   task automatic wait_done(input int lim, input logic busy_exp);
      n = 0;
      do begin
         @(negedge clock);
         n++;
         if (n == 2) chk("busy", busy_exp, conv_busy_flag);
      end while (conv_done_irq !== 1'b1 && n < lim);
   endtask
   task automatic t_reset;
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], d);
         chk("reset reg", 16'h0, d);
      end
      chk("reset busy", 16'h0, conv_busy_flag);
   endtask
   task automatic t_single(input logic [2:0] ack, input logic [3:0] ch, input int cyc);
      wr(2'h1, {3'b000, 1'b1, ack, 1'b0});
      wr(2'h0, {1'b0, `SADC_MODE_SW, 1'b0, ch});
      wr(2'h0, {1'b1, `SADC_MODE_SW, 1'b0, ch});
      wait_done(cyc + 10, 1'b1);
      chk("conv cycles", cyc + 2, n);
      chk("busy at end", 16'h0, conv_busy_flag);
      @(negedge clock);
      chk("irq pulse", 16'h0, conv_done_irq);
      rd(2'h0, d);
      chk("start bit", 16'h0, d[7]);
      get_result;
      chk("done flag", 16'h1, st[5]);
      chk("result", level[ch], r);
      rd(2'h3, st);
      chk("done cleared", 16'h0, st[5]);
   endtask
   task automatic t_restart;
      wr(2'h0, {1'b1, `SADC_MODE_SW, 1'b0, 4'h6});
      wait_done(60, 1'b1);
      wr(2'h0, {1'b1, `SADC_MODE_SW, 1'b0, 4'h3});
      rd(2'h3, st);
      chk("restart done", 16'h0, st[5]);
      rd(2'h2, d);
      chk("old result", level[6][9:2], d);
      wr(2'h0, {1'b1, `SADC_MODE_SW, 1'b0, 4'h3});
      wait_done(60, 1'b1);
      chk("busy restart cycles", 16'd35, n);
      get_result;
      chk("new result", level[3], r);
   endtask
   task automatic t_repeat;
      wr(2'h0, {1'b1, `SADC_MODE_REP, 1'b0, 4'h2});
      wait_done(60, 1'b1);
      chk("first cycles", 16'd41, n);
      wait_done(45, 1'b1);
      chk("repeat irq", 16'h1, conv_done_irq);
      get_result;
      chk("repeat result", level[2], r);
      @(posedge clock);
      level[2] <= 10'h011;
      wr(2'h0, {1'b0, `SADC_MODE_DIS, 1'b0, 4'h2});
      @(negedge clock);
      @(negedge clock);
      chk("halt busy", 16'h0, conv_busy_flag);
      wait_done(100, 1'b0);
      chk("halt irq", 16'h0, conv_done_irq);
      rd(2'h2, d);
      chk("kept result", 16'h55, d);
   endtask
   task automatic t_refuse;
      for (int m = 0; m < 3; m += 2) begin
         wr(2'h0, {1'b1, m[1:0], 1'b0, 4'h1});
         wait_done(60, 1'b0);
         chk("no start", 16'h0, conv_done_irq);
      end
   endtask
   task automatic t_standby;
      wr(2'h1, {2'b00, 1'b1, 1'b1, 3'h6, 1'b0});
      wr(2'h0, {1'b1, `SADC_MODE_SW, 1'b0, 4'h4});
      repeat (20) @(negedge clock);
      chk("ladder on", 16'h1, ladder_connect);
      @(posedge clock);
      standby_stop_slow <= 1'b1;
      repeat (3) @(negedge clock);
      chk("standby busy", 16'h0, conv_busy_flag);
      chk("ladder off", 16'h0, ladder_connect);
      wr(2'h0, 8'h81);
      wr(2'h1, 8'h3e);
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], d);
         chk("standby reg", 16'h0, d);
      end
      @(posedge clock);
      standby_stop_slow <= 1'b0;
      wait_done(1300, 1'b0);
      chk("no resume", 16'h0, conv_done_irq);
      t_single(3'h0, 4'h1, 39);
      @(posedge clock);
      standby_sleep <= 1'b1;
      wr(2'h0, {1'b1, `SADC_MODE_SW, 1'b0, 4'h1});
      rd(2'h0, d);
      chk("sleep ctrl", 16'h0, d);
      @(posedge clock);
      standby_sleep <= 1'b0;
      rd(2'h2, d);
      chk("sleep result", level[1][9:2], d);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_single(3'h0, 4'h3, 39);
      t_single(3'h2, 4'h0, 78);
      t_single(3'h3, 4'h1, 156);
      t_single(3'h4, 4'h2, 312);
      t_single(3'h5, 4'h4, 624);
      t_single(3'h6, 4'h7, 1248);
      t_single(3'h1, 4'h5, 1248);
      t_single(3'h0, 4'h6, 39);
      t_restart;
      t_repeat;
      t_refuse;
      t_standby;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      $display("[ERR] watchdog expected finish seen hang");
      tally_and_finish;
   end
endmodule
`default_nettype wire
